// ===== verilog/prcs_regs.svh
// Overview of operation
// - one setting picks the command source
// - open polarity pair means contact closures
// - shorted polarity pair means voltage inputs
// - method one starts on qualified start
// - method one stops when stop-enable drops
// - method two runs while start held
// - method two stops when start drops
// - voltage method one stops without stop-enable
// - valid start reaccelerates a decelerating rotor
// - qualified reset clears latched failure
// - rotation lamp off, green or orange
// - rotation lamp flash count shows speed
// - warning flashes orange with coded pattern
// - failure shows red with coded pattern
// - remote inputs ignored unless parallel selected
`ifndef PRCS_REGS_SVH
`define PRCS_REGS_SVH

// clock period in ns (50 MHz)
`define PRCS_CLK_NS      32'h00000014
// least start and reset pulse width, 300,000,000 ns
`define PRCS_QUAL_NS     32'h11e1a300
// least pulse rounded up to whole clock cycles
`define PRCS_QUAL_CYC \
  ((`PRCS_QUAL_NS + `PRCS_CLK_NS - 32'h1) / `PRCS_CLK_NS)
// lamp flash slot, 100,000,000 ns
`define PRCS_SLOT_NS     32'h05f5e100
// flash slot in cycles, rounded down
`define PRCS_SLOT_CYC    (`PRCS_SLOT_NS / `PRCS_CLK_NS)
// dark slots added after the off slot of the last flash
`define PRCS_FLASH_GAP   5'h04
// speed band limits in rpm
`define PRCS_RPM_BAND1   16'h07d0
`define PRCS_RPM_BAND2   16'h2710
`define PRCS_RPM_BAND3   16'h4e20
`define PRCS_RPM_BAND4   16'h5fb4
// flash pattern codes
`define PRCS_PAT_STEADY  4'h0
`define PRCS_PAT_CONT    4'hf
`define PRCS_PAT_ONE     4'h1
`define PRCS_PAT_TWO     4'h2
`define PRCS_PAT_THREE   4'h3

`endif

// ===== verilog/prcs_pkg.sv
package prcs_pkg;

  // command source chosen by the input operation port setting
  typedef enum logic [2:0] {
    PRCS_SRC_PARALLEL = 3'b000,
    PRCS_SRC_SERIAL1  = 3'b001,
    PRCS_SRC_SERIAL2  = 3'b010,
    PRCS_SRC_SERIAL3  = 3'b011,
    PRCS_SRC_SERIAL4  = 3'b100
  } prcs_src_t;

  // rotor phase reported by the motor control
  typedef enum logic [1:0] {
    PRCS_PH_LEVITATE = 2'b00,
    PRCS_PH_ACCEL    = 2'b01,
    PRCS_PH_NORMAL   = 2'b10,
    PRCS_PH_DECEL    = 2'b11
  } prcs_phase_t;

endpackage

// ===== verilog/prcs_flash.sv
`timescale 1ns/10ps
`include "prcs_regs.svh"

module prcs_flash
  import prcs_pkg::*;
(
  input  wire logic       core_clk_in,   // system clock
  input  wire logic       arst_n_in,     // async reset, low
  input  wire logic       tick_in,       // one pulse per slot
  input  wire logic       enable_in,     // lamp lit at all
  input  wire logic [3:0] pattern_in,    // flash pattern code
  output logic            lamp_out       // lamp drive
);

  // all state of the pattern generator
  typedef struct packed {
    logic [4:0] slot;   // slot within a flash frame
    logic       lamp;   // registered lamp level
  } prcs_flash_st_t;

  prcs_flash_st_t st_reg;   // present state
  prcs_flash_st_t st_next;  // next state
  logic [4:0]     limit;    // last slot of the frame
  logic [4:0]     lit_end;  // first slot after flashes

  // next state: frame walk and lamp level
  always_comb begin
    st_next = st_reg;
    lit_end = {pattern_in, 1'b0};
    if (pattern_in == `PRCS_PAT_CONT) begin
      // continuous flash: on, off, on, off
      limit = 5'h01;
    end else begin
      // n flashes then a dark gap
      limit = lit_end + `PRCS_FLASH_GAP - 5'h01;
    end
    if (!enable_in) begin
      // dark lamp restarts the frame
      st_next.slot = 5'h00;
      st_next.lamp = 1'b0;
    end else begin
      if (tick_in) begin
        if (st_reg.slot >= limit) begin
          st_next.slot = 5'h00;
        end else begin
          st_next.slot = st_reg.slot + 5'h01;
        end
      end
      if (pattern_in == `PRCS_PAT_STEADY) begin
        st_next.lamp = 1'b1;
      end else if (pattern_in == `PRCS_PAT_CONT) begin
        st_next.lamp = ~st_next.slot[0];
      end else begin
        st_next.lamp = (st_next.slot < lit_end) & ~st_next.slot[0];
      end
    end
  end

  // state register
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign lamp_out = st_reg.lamp;

endmodule

// ===== verilog/prcs_top.sv
`timescale 1ns/10ps
`include "prcs_regs.svh"

module prcs_top
  import prcs_pkg::*;
#(
  // least start and reset pulse, in cycles
  parameter int unsigned QUAL_CYCLES = `PRCS_QUAL_CYC,
  // lamp flash slot, in cycles
  parameter int unsigned SLOT_CYCLES = `PRCS_SLOT_CYC
)
(
  input  wire logic        core_clk_in,       // system clock
  input  wire logic        arst_n_in,         // async reset, low
  input  wire prcs_src_t   source_sel_in,     // command source
  input  wire logic        polarity_short_in, // polarity pair shorted
  input  wire logic        method_two_in,     // 1: start method two
  input  wire logic        start_pin_in,      // start pin level
  input  wire logic        stop_en_pin_in,    // stop-enable pin level
  input  wire logic        reset_pin_in,      // reset pin level
  input  wire logic        power_ok_in,       // supply present
  input  wire prcs_phase_t rotor_phase_in,    // rotor phase
  input  wire logic [15:0] speed_rpm_in,      // rotor speed, rpm
  input  wire logic        warning_in,        // a warning is active
  input  wire logic [3:0]  warning_code_in,   // warning pattern
  input  wire logic        failure_in,        // failure detected
  input  wire logic [3:0]  failure_code_in,   // failure pattern
  output logic             run_cmd_out,       // rotor run command
  output logic             fault_latched_out, // safety function held
  output logic             power_led_out,     // power lamp green
  output logic             rot_green_out,     // rotation lamp green
  output logic             rot_orange_out,    // rotation lamp orange
  output logic             fail_orange_out,   // failure lamp orange
  output logic             fail_red_out       // failure lamp red
);

  // counter limits at counter width
  // the casts keep both limits at the width of their counters
  localparam logic [23:0] QUAL_L = 24'(QUAL_CYCLES);
  localparam logic [22:0] SLOT_L = 23'(SLOT_CYCLES);

  // all state of the block outside the two flash generators
  typedef struct packed {
    logic        start_s1;   // start sync, first stage
    logic        start_s2;   // start sync, second stage
    logic        stop_s1;    // stop-enable sync, first
    logic        stop_s2;    // stop-enable sync, second
    logic        rst_s1;     // reset sync, first stage
    logic        rst_s2;     // reset sync, second stage
    logic [1:0]  warm;       // sync stages filled since reset
    logic [23:0] start_cnt;  // start pulse width
    logic [23:0] reset_cnt;  // reset pulse width
    logic [22:0] slot_cnt;   // flash time base
    logic        tick;       // slot pulse
    logic        run;        // run command
    logic        fault;      // latched failure
    logic [3:0]  fail_code;  // captured failure code
    logic        pwr_led;    // power lamp
    logic        rot_g;      // rotation lamp green
    logic        rot_o;      // rotation lamp orange
    logic        fail_o;     // failure lamp orange
    logic        fail_r;     // failure lamp red
  } prcs_st_t;

  prcs_st_t    st_reg;       // present state
  prcs_st_t    st_next;      // next state
  logic        start_act;    // start asserted
  logic        stop_act;     // stop-enable asserted
  logic        rst_act;      // reset asserted
  logic        remote_ok;    // parallel port is the source
  logic        pins_ok;      // remote pins may act
  logic        start_qual;   // start pulse just qualified
  logic        reset_qual;   // reset pulse just qualified
  logic        rot_lit;      // rotation lamp lit
  logic [3:0]  rot_pat;      // rotation flash pattern
  logic        fail_lit;     // failure lamp lit
  logic [3:0]  fail_pat;     // failure flash pattern
  logic        rot_lamp;     // rotation pattern output
  logic        fail_lamp;    // failure pattern output

  // maps a pin level to asserted, per input style
  function automatic logic pin_active(input logic pol_short,
                                      input logic level);
    // open pair, closed contact pulls low
    pin_active = pol_short ? level : ~level;
  endfunction

  // saturating pulse-width counter step
  function automatic logic [23:0] width_step(input logic act,
                                             input logic [23:0] cnt);
    // a dropped input restarts the count
    if (!act) begin
      width_step = 24'h000000;
    end else if (cnt >= QUAL_L) begin
      // saturate so a held pin qualifies only once
      width_step = cnt;
    end else begin
      width_step = cnt + 24'h000001;
    end
  endfunction

  // speed band to flash pattern
  function automatic logic [3:0] speed_band(input logic [15:0] rpm);
    if (rpm <= `PRCS_RPM_BAND1) begin
      speed_band = `PRCS_PAT_ONE;
    end else if (rpm <= `PRCS_RPM_BAND2) begin
      speed_band = `PRCS_PAT_TWO;
    end else if (rpm <= `PRCS_RPM_BAND3) begin
      speed_band = `PRCS_PAT_THREE;
    end else if (rpm < `PRCS_RPM_BAND4) begin
      speed_band = `PRCS_PAT_CONT;
    end else begin
      speed_band = `PRCS_PAT_STEADY;
    end
  endfunction

  // decoded inputs, remote pins from second sync stage, source select unsynchronised
  always_comb begin
    unique case (source_sel_in)
      PRCS_SRC_PARALLEL: remote_ok = 1'b1;
      PRCS_SRC_SERIAL1:  remote_ok = 1'b0;
      PRCS_SRC_SERIAL2:  remote_ok = 1'b0;
      PRCS_SRC_SERIAL3:  remote_ok = 1'b0;
      PRCS_SRC_SERIAL4:  remote_ok = 1'b0;
      default:           remote_ok = 1'b0;
    endcase
    // sync flops reset to zero, which contact wiring reads as a
    // closed contact: keep the pins off until both stages are real
    pins_ok = remote_ok & st_reg.warm[1];
    // other sources mask the remote pins
    start_act = pins_ok & pin_active(polarity_short_in,
                                     st_reg.start_s2);
    stop_act  = pins_ok & pin_active(polarity_short_in,
                                     st_reg.stop_s2);
    rst_act   = pins_ok & pin_active(polarity_short_in,
                                     st_reg.rst_s2);
    // qualified on the cycle the width is reached
    // the equality makes each qualify strobe one cycle long
    start_qual = start_act & stop_act &
                 (st_reg.start_cnt == QUAL_L - 24'h000001);
    reset_qual = rst_act &
                 (st_reg.reset_cnt == QUAL_L - 24'h000001);
  end

  // lamp selection from rotor and fault state
  always_comb begin
    unique case (rotor_phase_in)
      PRCS_PH_LEVITATE: begin
        // dark whatever the speed reads
        rot_lit = 1'b0;
        rot_pat = `PRCS_PAT_STEADY;
      end
      PRCS_PH_ACCEL: begin
        // speed band while spinning up
        rot_lit = 1'b1;
        rot_pat = speed_band(speed_rpm_in);
      end
      PRCS_PH_NORMAL: begin
        rot_lit = 1'b1;
        rot_pat = `PRCS_PAT_STEADY;
      end
      PRCS_PH_DECEL: begin
        // same bands while coasting down
        rot_lit = 1'b1;
        rot_pat = speed_band(speed_rpm_in);
      end
    endcase
    if (st_reg.fault) begin
      // failure code drives the red pattern
      fail_lit = 1'b1;
      fail_pat = st_reg.fail_code;
    end else if (warning_in) begin
      fail_lit = 1'b1;
      if (warning_code_in == `PRCS_PAT_STEADY) begin
        fail_pat = `PRCS_PAT_CONT;
      end else begin
        fail_pat = warning_code_in;
      end
    end else begin
      // no fault and no warning: lamp dark
      fail_lit = 1'b0;
      fail_pat = `PRCS_PAT_STEADY;
    end
  end

  // both lamps share one slot tick, so their flashes line up
  // rotation lamp pattern
  prcs_flash u_rot_flash (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .tick_in     (st_reg.tick),
    .enable_in   (rot_lit),
    .pattern_in  (rot_pat),
    .lamp_out    (rot_lamp)
  );

  // failure lamp pattern
  prcs_flash u_fail_flash (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .tick_in     (st_reg.tick),
    .enable_in   (fail_lit),
    .pattern_in  (fail_pat),
    .lamp_out    (fail_lamp)
  );

  // next state of the whole block
  always_comb begin
    st_next = st_reg;
    st_next.start_s1 = start_pin_in;
    st_next.start_s2 = st_reg.start_s1;
    st_next.stop_s1  = stop_en_pin_in;
    st_next.stop_s2  = st_reg.stop_s1;
    st_next.rst_s1   = reset_pin_in;
    st_next.rst_s2   = st_reg.rst_s1;
    // warm-up shift, full two edges after reset
    st_next.warm     = {st_reg.warm[0], 1'b1};
    // start width counts only under stop-enable
    st_next.start_cnt = width_step(start_act & stop_act,
                                   st_reg.start_cnt);
    st_next.reset_cnt = width_step(rst_act, st_reg.reset_cnt);
    // slow time base for the lamps
    if (st_reg.slot_cnt >= SLOT_L - 23'h000001) begin
      st_next.slot_cnt = 23'h000000;
      st_next.tick     = 1'b1;
    end else begin
      st_next.slot_cnt = st_reg.slot_cnt + 23'h000001;
      st_next.tick     = 1'b0;
    end
    // clear first, so a failure in the same cycle wins below
    // qualified reset clears the latch
    if (reset_qual) begin
      st_next.fault = 1'b0;
    end
    // a new failure wins over a reset
    if (failure_in) begin
      st_next.fault     = 1'b1;
      st_next.fail_code = failure_code_in;
    end
    // run command
    // with another source the pins are masked and run holds
    if (remote_ok) begin
      if (method_two_in) begin
        // start is a level, stop-enable ignored
        st_next.run = start_act;
      end else if (!stop_act) begin
        st_next.run = 1'b0;
      end else if (start_qual) begin
        // accepted at any rotor phase
        // no phase check, so a coasting rotor restarts
        st_next.run = 1'b1;
      end
    end
    // latched failure forces a stop
    // taken from the next value so the stop lands with the latch
    if (st_next.fault) begin
      st_next.run = 1'b0;
    end
    // every lamp output is registered, so lamps trail by a cycle
    // power lamp follows supply only
    st_next.pwr_led = power_ok_in;
    st_next.rot_g = rot_lamp &
                    (rotor_phase_in != PRCS_PH_DECEL);
    st_next.rot_o = rot_lamp &
                    (rotor_phase_in == PRCS_PH_DECEL);
    st_next.fail_o = fail_lamp & ~st_reg.fault;
    st_next.fail_r = fail_lamp & st_reg.fault;
  end

  // state register
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flops
  // no logic between the state flops and the pins
  assign run_cmd_out       = st_reg.run;
  assign fault_latched_out = st_reg.fault;
  assign power_led_out     = st_reg.pwr_led;
  assign rot_green_out     = st_reg.rot_g;
  assign rot_orange_out    = st_reg.rot_o;
  assign fail_orange_out   = st_reg.fail_o;
  assign fail_red_out      = st_reg.fail_r;

endmodule

// ===== verification/prcs_remote_model.sv
`timescale 1ns/10ps
// control equipment on the remote connector: commands become pin levels
module prcs_remote_model (
  input  wire logic volt_mode_in,   // 1: voltage wiring, 0: contacts
  input  wire logic want_start_in,  // start command held
  input  wire logic want_stop_in,   // stop-enable command held
  input  wire logic want_reset_in,  // reset command held
  output logic      start_pin_out,  // start pin level
  output logic      stop_pin_out,   // stop-enable pin level
  output logic      reset_pin_out   // reset pin level
);
  // closed contact pulls low, open contact floats high
  assign start_pin_out = want_start_in ~^ volt_mode_in;
  assign stop_pin_out  = want_stop_in ~^ volt_mode_in;
  assign reset_pin_out = want_reset_in ~^ volt_mode_in;
endmodule

// ===== verification/prcs_top_properties.sv
`timescale 1ns/10ps
// port-level checks on the remote front end and the lamps
module prcs_top_chk
  import prcs_pkg::*;
#(
  parameter int unsigned QUAL_CYCLES = 8,
  parameter int unsigned SLOT_CYCLES = 4
)
(
  input wire logic        core_clk_in,
  input wire logic        arst_n_in,
  input wire prcs_src_t   source_sel_in,
  input wire logic        polarity_short_in,
  input wire logic        method_two_in,
  input wire logic        start_pin_in,
  input wire logic        stop_en_pin_in,
  input wire logic        reset_pin_in,
  input wire logic        power_ok_in,
  input wire prcs_phase_t rotor_phase_in,
  input wire logic        warning_in,
  input wire logic        failure_in,
  input wire logic        run_cmd_out,
  input wire logic        fault_latched_out,
  input wire logic        power_led_out,
  input wire logic        rot_green_out,
  input wire logic        rot_orange_out,
  input wire logic        fail_orange_out,
  input wire logic        fail_red_out
);
  logic        par;       // parallel source chosen
  logic        st_a;      // start asserted
  logic        se_a;      // stop-enable asserted
  logic        rs_a;      // reset asserted
  int unsigned qcnt_reg;  // cycles start and stop-enable held
  int unsigned rcnt_reg;  // cycles reset held
  assign par  = source_sel_in == PRCS_SRC_PARALLEL;
  assign st_a = start_pin_in ~^ polarity_short_in;
  assign se_a = stop_en_pin_in ~^ polarity_short_in;
  assign rs_a = reset_pin_in ~^ polarity_short_in;
  // run lengths of the qualifying inputs
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      qcnt_reg <= 0;
      rcnt_reg <= 0;
    end else begin
      qcnt_reg <= (par && st_a && se_a) ? qcnt_reg + 1 : 0;
      rcnt_reg <= (par && rs_a) ? rcnt_reg + 1 : 0;
    end
  end
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!arst_n_in);
  power_lamp_a: assert property (
    power_ok_in [*2] |-> power_led_out) else $error("power lamp dark");
  start_qual_a: assert property (
    $rose(run_cmd_out) && !method_two_in |-> qcnt_reg >= QUAL_CYCLES + 1)
    else $error("run began without qualified start");
  one_stop_a: assert property (
    (par && !method_two_in && !se_a) [*4] |-> !run_cmd_out)
    else $error("run held without stop-enable");
  two_stop_a: assert property (
    (par && method_two_in && !st_a) [*4] |-> !run_cmd_out)
    else $error("run held without start level");
  two_run_a: assert property (
    (par && method_two_in && st_a && !failure_in && !fault_latched_out) [*4]
    |-> run_cmd_out) else $error("run missing with start level");
  reset_qual_a: assert property (
    $fell(fault_latched_out) |-> rcnt_reg >= QUAL_CYCLES + 1)
    else $error("fault cleared by short reset");
  fault_set_a: assert property (
    failure_in |=> fault_latched_out && !run_cmd_out)
    else $error("failure not latched");
  remote_mask_a: assert property (
    (!par && !failure_in) [*3] |=>
    $stable(run_cmd_out) && $stable(fault_latched_out))
    else $error("remote pins acted while masked");
  rot_off_a: assert property (
    (rotor_phase_in == PRCS_PH_LEVITATE) [*3]
    |-> !rot_green_out && !rot_orange_out) else $error("rotation lamp lit");
  fail_lamp_a: assert property (
    (!fault_latched_out && !warning_in) [*3]
    |-> !fail_orange_out && !fail_red_out) else $error("failure lamp lit");
endmodule
bind prcs_top prcs_top_chk #(.QUAL_CYCLES(QUAL_CYCLES),
  .SLOT_CYCLES(SLOT_CYCLES)) i_prcs_top_chk (
  .core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
  .source_sel_in(source_sel_in), .polarity_short_in(polarity_short_in),
  .method_two_in(method_two_in), .start_pin_in(start_pin_in),
  .stop_en_pin_in(stop_en_pin_in), .reset_pin_in(reset_pin_in),
  .power_ok_in(power_ok_in), .rotor_phase_in(rotor_phase_in),
  .warning_in(warning_in), .failure_in(failure_in),
  .run_cmd_out(run_cmd_out), .fault_latched_out(fault_latched_out),
  .power_led_out(power_led_out), .rot_green_out(rot_green_out),
  .rot_orange_out(rot_orange_out), .fail_orange_out(fail_orange_out),
  .fail_red_out(fail_red_out));

// ===== verification/tb.sv
`timescale 1ns/10ps
module tb;
  import prcs_pkg::*;
  localparam int QC = 8;          // shortened pulse qualification
  logic        core_clk = 1'b0;   // 50 MHz clock
  logic        arst_n   = 1'b0;   // reset, low
  logic        pol      = 1'b0;   // contact wiring
  logic        m2       = 1'b0;   // start method two
  logic        w_st     = 1'b0;   // start wanted
  logic        w_se     = 1'b0;   // stop-enable wanted
  logic        w_rs     = 1'b0;   // reset wanted
  logic        pok      = 1'b1;   // supply present
  logic        warn     = 1'b0;   // warning active
  logic        fail     = 1'b0;   // failure event
  logic [15:0] rpm      = 16'h0;  // rotor speed
  logic [3:0]  wcode    = 4'h0;   // warning pattern
  logic [3:0]  fcode    = 4'h0;   // failure pattern
  prcs_src_t   src      = PRCS_SRC_PARALLEL;
  prcs_phase_t ph       = PRCS_PH_LEVITATE;
  logic        st_pin, se_pin, rs_pin, run, flt, pled, rg, ro, fo, fr;
  logic [3:0]  lamps;             // rotation green/orange, fail orange/red
  int          errors, cmp_count, cnt[4];
  logic [15:0] tab[6] = '{16'h07d0, 16'h07d1, 16'h2710, 16'h4e20,
                          16'h5fb3, 16'h5fb4};
  assign lamps = {rg, ro, fo, fr};
  prcs_remote_model i_prcs_remote_model (.volt_mode_in(pol),
    .want_start_in(w_st), .want_stop_in(w_se), .want_reset_in(w_rs),
    .start_pin_out(st_pin), .stop_pin_out(se_pin), .reset_pin_out(rs_pin));
  prcs_top #(.QUAL_CYCLES(QC), .SLOT_CYCLES(4)) i_prcs_top (
    .core_clk_in(core_clk), .arst_n_in(arst_n), .source_sel_in(src),
    .polarity_short_in(pol), .method_two_in(m2), .start_pin_in(st_pin),
    .stop_en_pin_in(se_pin), .reset_pin_in(rs_pin), .power_ok_in(pok),
    .rotor_phase_in(ph), .speed_rpm_in(rpm), .warning_in(warn),
    .warning_code_in(wcode), .failure_in(fail), .failure_code_in(fcode),
    .run_cmd_out(run), .fault_latched_out(flt), .power_led_out(pled),
    .rot_green_out(rg), .rot_orange_out(ro), .fail_orange_out(fo),
    .fail_red_out(fr));
  // free-running clock
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  // lit cycles in a 480-cycle window for a pattern code
  function automatic int exp_on(input logic [3:0] c, input logic w);
    if (c == 4'h0 && !w)
      return 480;
    if (c == 4'h0 || c == 4'hf)
      return 240;
    return (480 / (8 * c + 16)) * c * 4;
  endfunction
  // speed band to pattern code
  function automatic logic [3:0] band(input logic [15:0] r);
    if (r <= 16'h07d0)
      return 4'h1;
    if (r <= 16'h2710)
      return 4'h2;
    if (r <= 16'h4e20)
      return 4'h3;
    return (r < 16'h5fb4) ? 4'hf : 4'h0;
  endfunction
  task automatic step(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input string nm, input int e, input logic [15:0] g);
    cmp_count++;
    if (g !== 16'(e)) begin
      errors++;
      $display("unexpected %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  // settle one frame, then count lit cycles of each lamp
  task automatic measure();
    cnt = '{default: 0};
    step(48);
    repeat (480) begin
      for (int k = 0; k < 4; k++)
        if (lamps[k] === 1'b1)
          cnt[k]++;
      step(1);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // cut a hang short
  initial begin
    #600000;
    errors++;
    final_report();
  end
  initial begin
    void'($urandom(32'hc5cbc018));
    step(8);
    arst_n = 1'b1;
    step(2);
    // rotation lamp colour and speed band, corners then random
    for (int i = 0; i < 9; i++) begin
      ph  = (i < 6) ? (i[0] ? PRCS_PH_DECEL : PRCS_PH_ACCEL)
                    : prcs_phase_t'($urandom_range(3));
      rpm = (i < 6) ? tab[i] : 16'($urandom_range(65535));
      pok = 1'($urandom_range(1));
      measure();
      n_chk();
    end
    $display("lamp test done");
    ph = PRCS_PH_LEVITATE;
    // warning codes on the failure lamp
    foreach (tab[i]) begin
      warn  = 1'b1;
      wcode = (i == 5) ? 4'hf : 4'(i);
      measure();
      chk("warn orange", exp_on(wcode, 1'b1), cnt[1]);
      chk("warn red", 0, cnt[0]);
    end
    warn = 1'b0;
    $display("warning test done");
    // method one in contact and voltage wiring
    for (int p = 0; p < 2; p++) begin
      pol  = p[0];
      step(4);
      w_se = 1'b1;
      step(2);
      w_st = 1'b1;
      step(QC - 3);
      w_st = 1'b0;
      step(QC + 4);
      chk("short start", 0, run);
      w_st = 1'b1;
      step(QC + 4);
      chk("start", 1, run);
      w_st = 1'b0;
      w_se = 1'b0;
      step(4);
      chk("stop", 0, run);
      w_st = 1'b1;
      step(QC + 4);
      chk("start alone", 0, run);
      w_st = 1'b0;
      ph   = PRCS_PH_DECEL;
      w_se = 1'b1;
      step(2);
      w_st = 1'b1;
      step(QC + 4);
      chk("reaccel", 1, run);
      w_st = 1'b0;
      w_se = 1'b0;
      step(4);
      chk("stop2", 0, run);
    end
    // start held long as the power unit comes up
    pok  = 1'b0;
    w_se = 1'b1;
    step(4);
    chk("power off", 0, pled);
    pok  = 1'b1;
    w_st = 1'b1;
    step(QC * 34);
    chk("power-on start", 1, run);
    w_st = 1'b0;
    w_se = 1'b0;
    step(4);
    chk("stop3", 0, run);
    $display("method one test done");
    // method two follows start level, stop-enable ignored
    m2 = 1'b1;
    for (int i = 0; i < 8; i++) begin
      w_se = 1'($urandom_range(1));
      w_st = i[0];
      step(4 + $urandom_range(3));
      chk("level run", w_st, run);
    end
    w_st = 1'b0;
    step(4);
    chk("level stop", 0, run);
    m2   = 1'b0;
    $display("method two test done");
    // serial sources mask the remote pins
    w_se = 1'b1;
    w_st = 1'b1;
    step(QC + 4);
    w_st = 1'b0;
    w_se = 1'b0;
    for (int s = 1; s < 8; s++) begin
      src = prcs_src_t'(s);
      step(4);
      chk("masked stop", 1, run);
    end
    $display("mask test done");
    // latched failure, masked and short resets, then a real one
    fcode = 4'($urandom_range(1, 4));
    fail  = 1'b1;
    step(1);
    fail  = 1'b0;
    step(2);
    chk("fault", 1, flt);
    chk("fault run", 0, run);
    measure();
    chk("fail red", exp_on(fcode, 1'b0), cnt[0]);
    w_rs = 1'b1;
    step(QC + 4);
    chk("masked reset", 1, flt);
    w_rs = 1'b0;
    src  = PRCS_SRC_PARALLEL;
    step(2);
    w_rs = 1'b1;
    step(QC - 3);
    w_rs = 1'b0;
    step(QC);
    chk("short reset", 1, flt);
    // reset once the rotation lamp is dark
    ph   = PRCS_PH_LEVITATE;
    w_rs = 1'b1;
    step(QC + 4);
    w_rs = 1'b0;
    chk("reset", 0, flt);
    measure();
    chk("red off", 0, cnt[0]);
    $display("fault test done");
    final_report();
  end
  // rotation lamp counts and power lamp against the current setting
  task automatic n_chk();
    int e;
    e = (ph == PRCS_PH_LEVITATE) ? 0 :
        (ph == PRCS_PH_NORMAL) ? 480 : exp_on(band(rpm), 1'b0);
    chk("green", ph == PRCS_PH_DECEL ? 0 : e, cnt[3]);
    chk("orange", ph == PRCS_PH_DECEL ? e : 0, cnt[2]);
    chk("power", pok, pled);
  endtask
endmodule
